// ==== common/sspf_pkg.sv ====
package sspf_pkg;
    // ==========================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] ts_off = 8'h04;
    localparam logic [7:0] len_off = 8'h08;
    localparam logic [7:0] tok_off = 8'h0c;
    localparam logic [7:0] seg_off = 8'h10;
    localparam logic [7:0] stat_off = 8'h14;
    localparam logic [7:0] seq_off = 8'h18;
    localparam logic [7:0] cnt_off = 8'h1c;
    // ctrl fields
    localparam int ctrl_start_bit = 0;
    localparam int ctrl_kind_bit = 1;
    localparam int ctrl_alt_bit = 2;
    // ==========================================
    // rtp header constants
    localparam logic [7:0] rtp_byte0 = 8'h80;
    localparam logic [6:0] pt_auth = 7'h4f;
    localparam logic [6:0] pt_pubkey = 7'h50;
    localparam logic [6:0] pt_pubkey_alt = 7'h51;
    localparam logic [31:0] ssrc_val = 32'h0000_0000;
    localparam logic [3:0] rtp_hdr_last = 4'hb;
    // ==========================================
    // inner structure header
    localparam logic [16:0] struct_hdr_len = 17'h00004;
    localparam logic [16:0] len_max = 17'h0ffff;
    localparam logic [3:0] ver_major = 4'h0;
    localparam logic [3:0] ver_minor = 4'h0;
    localparam logic [15:0] seg_default = 16'h0400;
    // ==========================================
    // stream destination
    localparam logic [31:0] dest_ip = 32'hef00_3330;
    localparam logic [15:0] dest_port = 16'h7572;
endpackage : sspf_pkg

// ==== core/sspf_buf.sv ====
`timescale 1ns/1ns
module sspf_buf #(
    parameter int W = 10,
    parameter int DEPTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [W-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [W-1:0] m_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] depth_c = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] last_c = AW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    wire push = s_valid && s_ready;
    wire pop = m_valid && m_ready;

    // ==========================================
    // handshakes
    assign s_ready = fill != depth_c;
    assign m_valid = fill != '0;
    assign m_data = mem[rp];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp <= '0;
            rp <= '0;
            fill <= '0;
        end else begin
            if (push) wp <= (wp == last_c) ? '0 : wp + 1'b1;
            if (pop) rp <= (rp == last_c) ? '0 : rp + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage has no reset; it is never read while empty
    always_ff @(posedge pclk) begin
        if (push) mem[wp] <= s_data;
    end
endmodule : sspf_buf

// ==== core/sspf_framer.sv ====
`timescale 1ns/1ns
module sspf_framer #(
    parameter logic [15:0] SEQ_INIT = 16'h0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_sop,
    output logic out_eop,
    output logic [31:0] out_dest_ip,
    output logic [15:0] out_dest_port,
    output logic busy
);
    typedef enum logic [1:0] {
        sspf_idle_s,
        sspf_hdr_s,
        sspf_body_s
    } sspf_state_t;

    // ==========================================
    // software registers
    logic kind_pubkey;
    logic use_alt_pt;
    logic [31:0] ts_cfg;
    logic [15:0] len_cfg;
    logic [7:0] tok_cfg;
    logic [15:0] seg_cfg;
    logic len_err;
    logic [31:0] set_cnt;

    // ==========================================
    // framing state
    sspf_state_t state;
    logic [15:0] seq;
    logic [31:0] ts_set;
    logic [6:0] pt_set;
    logic [15:0] struct_len;
    logic [7:0] tok_set;
    logic marker;
    logic [3:0] hidx;
    logic [16:0] pos;
    logic [16:0] left;
    logic [16:0] seg_left;

    // ==========================================
    // apb decode; zero wait states
    wire wr_acc = psel && penable && pwrite;
    wire hit_ctrl = paddr == sspf_pkg::ctrl_off;
    wire hit_ts = paddr == sspf_pkg::ts_off;
    wire hit_len = paddr == sspf_pkg::len_off;
    wire hit_tok = paddr == sspf_pkg::tok_off;
    wire hit_seg = paddr == sspf_pkg::seg_off;
    wire hit_stat = paddr == sspf_pkg::stat_off;
    wire hit_seq = paddr == sspf_pkg::seq_off;
    wire hit_cnt = paddr == sspf_pkg::cnt_off;
    wire hit_any = hit_ctrl || hit_ts || hit_len || hit_tok || hit_seg
        || hit_stat || hit_seq || hit_cnt;
    wire start_req = wr_acc && hit_ctrl && pwdata[sspf_pkg::ctrl_start_bit];

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    wire [31:0] ctrl_rd = {29'h0, use_alt_pt, kind_pubkey, 1'b0};
    wire [31:0] stat_rd = {30'h0, len_err, busy};
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_rd :
        hit_ts ? ts_cfg :
        hit_len ? {16'h0, len_cfg} :
        hit_tok ? {24'h0, tok_cfg} :
        hit_seg ? {16'h0, seg_cfg} :
        hit_stat ? stat_rd :
        hit_seq ? {16'h0, seq} :
        hit_cnt ? set_cnt : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (psel && !penable && !pwrite) prdata <= rd_mux;
    end

    // ==========================================
    // set geometry
    // length field counts its own four header bytes plus the sealed bytes
    wire [16:0] total_len = {1'b0, len_cfg} + sspf_pkg::struct_hdr_len;
    wire too_long = total_len > sspf_pkg::len_max;
    // a zero segment size is read as one byte to keep progress
    wire [16:0] seg_eff = (seg_cfg == 16'h0) ? 17'h1 : {1'b0, seg_cfg};

    function automatic logic [16:0] seg_first(input logic [16:0] s,
                                              input logic [16:0] l);
        seg_first = (s < l) ? s : l;
    endfunction : seg_first

    // ==========================================
    // payload type choice
    // a start may carry its own kind bits, so the type follows the word being written
    wire ctrl_wr = wr_acc && hit_ctrl;
    wire kind_now = ctrl_wr ? pwdata[sspf_pkg::ctrl_kind_bit] : kind_pubkey;
    wire alt_now = ctrl_wr ? pwdata[sspf_pkg::ctrl_alt_bit] : use_alt_pt;
    wire [6:0] pt_sel = !kind_now ? sspf_pkg::pt_auth :
        (alt_now ? sspf_pkg::pt_pubkey_alt : sspf_pkg::pt_pubkey);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_pubkey <= 1'b0;
            use_alt_pt <= 1'b0;
            ts_cfg <= 32'h0;
            len_cfg <= 16'h0;
            tok_cfg <= 8'h0;
            seg_cfg <= sspf_pkg::seg_default;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                kind_pubkey <= pwdata[sspf_pkg::ctrl_kind_bit];
                use_alt_pt <= pwdata[sspf_pkg::ctrl_alt_bit];
            end
            if (hit_ts) ts_cfg <= pwdata;
            if (hit_len) len_cfg <= pwdata[15:0];
            if (hit_tok) tok_cfg <= pwdata[7:0];
            if (hit_seg) seg_cfg <= pwdata[15:0];
        end
    end

    // ==========================================
    // byte builders
    function automatic logic [7:0] rtp_byte(input logic [3:0] i,
                                            input logic m,
                                            input logic [6:0] pt,
                                            input logic [15:0] sq,
                                            input logic [31:0] ts);
        logic [7:0] b;
        b = 8'h0;
        unique case (i)
            4'h0: b = sspf_pkg::rtp_byte0;
            4'h1: b = {m, pt};
            4'h2: b = sq[15:8];
            4'h3: b = sq[7:0];
            4'h4: b = ts[31:24];
            4'h5: b = ts[23:16];
            4'h6: b = ts[15:8];
            4'h7: b = ts[7:0];
            4'h8: b = sspf_pkg::ssrc_val[31:24];
            4'h9: b = sspf_pkg::ssrc_val[23:16];
            4'ha: b = sspf_pkg::ssrc_val[15:8];
            4'hb: b = sspf_pkg::ssrc_val[7:0];
            default: b = 8'h0;
        endcase
        rtp_byte = b;
    endfunction : rtp_byte

    function automatic logic [7:0] struct_byte(input logic [1:0] i,
                                               input logic [15:0] len,
                                               input logic [7:0] tok);
        logic [7:0] b;
        b = 8'h0;
        unique case (i)
            2'h0: b = len[15:8];
            2'h1: b = len[7:0];
            2'h2: b = {sspf_pkg::ver_major, sspf_pkg::ver_minor};
            2'h3: b = tok;
        endcase
        struct_byte = b;
    endfunction : struct_byte

    // ==========================================
    // output path through the two-entry buffer
    logic buf_ready;
    logic [9:0] buf_out;
    wire in_hdr = pos < sspf_pkg::struct_hdr_len;
    wire is_hdr = state == sspf_hdr_s;
    wire is_body = state == sspf_body_s;
    wire seg_end = seg_left == 17'h1;
    wire set_end = left == 17'h1;
    wire body_has = in_hdr || in_valid;
    wire emit_valid = is_hdr || (is_body && body_has);
    wire emit = emit_valid && buf_ready;
    wire [7:0] emit_byte = is_hdr ? rtp_byte(hidx, marker, pt_set, seq, ts_set) :
        in_hdr ? struct_byte(pos[1:0], struct_len, tok_set) : in_data;
    wire emit_sop = is_hdr && (hidx == 4'h0);
    wire emit_eop = is_body && seg_end;

    // sealed bytes are pulled only when the buffer can take them
    assign in_ready = is_body && !in_hdr && buf_ready;
    assign busy = state != sspf_idle_s;

    sspf_buf #(
        .W(10),
        .DEPTH(2)
    ) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .s_valid(emit_valid),
        .s_ready(buf_ready),
        .s_data({emit_sop, emit_eop, emit_byte}),
        .m_valid(out_valid),
        .m_ready(out_ready),
        .m_data(buf_out)
    );

    assign out_sop = buf_out[9];
    assign out_eop = buf_out[8];
    assign out_data = buf_out[7:0];

    // ==========================================
    // destination, held for every packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_dest_ip <= sspf_pkg::dest_ip;
            out_dest_port <= sspf_pkg::dest_port;
        end else begin
            out_dest_ip <= sspf_pkg::dest_ip;
            out_dest_port <= sspf_pkg::dest_port;
        end
    end

    // ==========================================
    // error flag: start refused on oversize; a new good start clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) len_err <= 1'b0;
        else if (start_req && state == sspf_idle_s) len_err <= too_long;
    end

    // ==========================================
    // framing sequencer
    // a start while busy is ignored, so sets never interleave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sspf_idle_s;
            seq <= SEQ_INIT;
            ts_set <= 32'h0;
            pt_set <= sspf_pkg::pt_auth;
            struct_len <= 16'h0;
            tok_set <= 8'h0;
            marker <= 1'b0;
            hidx <= 4'h0;
            pos <= 17'h0;
            left <= 17'h0;
            seg_left <= 17'h0;
            set_cnt <= 32'h0;
        end else begin
            unique case (state)
                sspf_idle_s: begin
                    if (start_req && !too_long) begin
                        state <= sspf_hdr_s;
                        ts_set <= ts_cfg;
                        pt_set <= pt_sel;
                        struct_len <= total_len[15:0];
                        tok_set <= tok_cfg;
                        marker <= 1'b1;
                        hidx <= 4'h0;
                        pos <= 17'h0;
                        left <= total_len;
                        seg_left <= seg_first(seg_eff, total_len);
                    end
                end
                sspf_hdr_s: begin
                    if (emit) begin
                        hidx <= hidx + 4'h1;
                        if (hidx == sspf_pkg::rtp_hdr_last) state <= sspf_body_s;
                    end
                end
                sspf_body_s: begin
                    if (emit) begin
                        pos <= pos + 17'h1;
                        left <= left - 17'h1;
                        seg_left <= seg_left - 17'h1;
                        if (seg_end) begin
                            seq <= seq + 16'h1;
                            marker <= 1'b0;
                            hidx <= 4'h0;
                            if (set_end) begin
                                state <= sspf_idle_s;
                                set_cnt <= set_cnt + 32'h1;
                            end else begin
                                state <= sspf_hdr_s;
                                seg_left <= seg_first(seg_eff, left - 17'h1);
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule : sspf_framer

// ==== sim/sspf_chk.sv ====
`timescale 1ns/1ns
module sspf_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_sop,
    input wire logic [31:0] out_dest_ip,
    input wire logic [15:0] out_dest_port,
    input wire logic busy
);
    // ==========================================
    // helpers: byte index in packet, values software set up
    int bi, idx;
    logic first, kind, alt, take, wr, go;
    logic [31:0] ts_w;
    logic [15:0] len_w;
    logic [6:0] exp_pt;
    assign take = out_valid && out_ready;
    assign idx = out_sop ? 0 : bi;
    assign wr = psel && penable && pwrite;
    // a start only counts when idle and the length fits
    assign go = wr && paddr == 8'h00 && pwdata[0] && !busy && len_w < 16'hfffc;
    assign exp_pt = !kind ? 7'h4f : (alt ? 7'h51 : 7'h50);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bi <= 0;
            first <= 1'b0;
            kind <= 1'b0;
            alt <= 1'b0;
            ts_w <= 32'h0000_0000;
            len_w <= 16'h0000;
        end else begin
            bi <= take ? idx + 1 : bi;
            ts_w <= (wr && paddr == 8'h04) ? pwdata : ts_w;
            len_w <= (wr && paddr == 8'h08) ? pwdata[15:0] : len_w;
            first <= go || (first && !(take && idx == 1));
            kind <= go ? pwdata[1] : kind;
            alt <= go ? pwdata[2] : alt;
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_DEST_IP: assert property (out_dest_ip == 32'hef00_3330)
        else $error("destination group wrong");
    AST_DEST_PORT: assert property (out_dest_port == 16'h7572)
        else $error("destination port wrong");
    AST_BYTE0: assert property (take && idx == 0 |-> out_data == 8'h80)
        else $error("first header byte wrong");
    AST_PT: assert property (take && idx == 1 |-> out_data[6:0] == exp_pt)
        else $error("payload type wrong");
    AST_MARK: assert property (take && idx == 1 |-> out_data[7] == first)
        else $error("marker bit wrong");
    AST_TS: assert property (take && idx >= 4 && idx < 8 |->
        out_data == 8'(ts_w >> (8 * (7 - idx)))) else $error("timestamp byte wrong");
    AST_SSRC: assert property (take && idx >= 8 && idx < 12 |-> out_data == 8'h00)
        else $error("source identifier not zero");
    AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled byte lost or changed");
    AST_BUSY: assert property (go |=> busy)
        else $error("busy missing after start");
    AST_LAUNCH: assert property (go |-> ##[1:6] (out_valid && out_sop))
        else $error("packet did not begin after start");
    AST_INREADY: assert property (in_ready |-> busy)
        else $error("payload pulled while idle");
    AST_SLVERR: assert property (psel && penable && (paddr[1:0] != 2'b00 || paddr > 8'h1c)
        |-> pslverr) else $error("unmapped access not refused");
    cover property (go && pwdata[2]);
    cover property (out_valid && !out_ready);
    cover property (psel && penable && pslverr);
endmodule : sspf_chk

bind sspf_framer sspf_chk sspf_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_sop(out_sop), .out_dest_ip(out_dest_ip), .out_dest_port(out_dest_port), .busy(busy));

// ==== sim/sspf_framer_tb.sv ====
`timescale 1ns/1ns
module sspf_framer_tb;
    logic pclk, presetn, psel, penable, pwrite, in_valid, out_ready, slow, err;
    logic [7:0] paddr, in_data, out_data, mpt, tok;
    logic [31:0] pwdata, prdata, out_dest_ip, ts, rd;
    logic [15:0] out_dest_port;
    logic pready, pslverr, in_ready, out_valid, out_sop, out_eop, busy;
    int n_fail, tests_run, pkts, sets_ok, drops, bad;
    logic [2:0] ctl [3] = '{3'b001, 3'b011, 3'b111};
    logic [6:0] ptv [3] = '{7'h4f, 7'h50, 7'h51};
    sspf_framer sspf_framer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop),
        .out_eop(out_eop), .out_dest_ip(out_dest_ip), .out_dest_port(out_dest_port),
        .busy(busy));
    sspf_sink sspf_sink_i (.pclk(pclk), .presetn(presetn), .slow(slow), .valid(out_valid),
        .data(out_data), .sop(out_sop), .eop(out_eop), .ready(out_ready), .mpt(mpt), .ts(ts),
        .tok(tok), .pkts(pkts), .sets_ok(sets_ok), .drops(drops), .bad(bad));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // payload source always offers the next counting byte
    always @(posedge pclk) begin
        if (!presetn) in_data <= 8'h00;
        else if (in_valid && in_ready) in_data <= in_data + 8'h01;
    end
    // ==========================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_pkts(input int n);
        int c;
        c = 0;
        while (pkts < n && c < 3000) begin
            @(posedge pclk);
            c++;
        end
        chk("packet count", 32'(pkts), 32'(n));
        repeat (4) @(posedge pclk);
    endtask : wait_pkts
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // tests
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        in_valid = 1'b1;
        slow = 1'b0;
        n_fail = 0;
        tests_run = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        chk("segment reset", rd, 32'h400);
        apb(1'b0, 8'h14, 32'h0);
        chk("status reset", rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            slow <= k[0];
            apb(1'b1, 8'h04, 32'h1234_5600 + k);
            apb(1'b1, 8'h08, 32'h6);
            apb(1'b1, 8'h0c, 32'(k * 100));
            apb(1'b1, 8'h10, 32'h4);
            apb(1'b1, 8'h00, {29'h0, ctl[k]});
            apb(1'b1, 8'h00, {29'h0, ctl[k]});
            wait_pkts(3 * (k + 1));
            chk("payload type", {24'h0, mpt}, {25'h0, ptv[k]});
            chk("timestamp", ts, 32'h1234_5600 + k);
            chk("token count", {24'h0, tok}, 32'(k * 100));
            chk("sets joined", 32'(sets_ok), 32'(k + 1));
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk("sets sent", rd, 32'h3);
        apb(1'b0, 8'h18, 32'h0);
        chk("next sequence", rd, 32'h9);
        $display("test modes done");
        apb(1'b1, 8'h10, 32'hffff);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        wait_pkts(10);
        chk("single packet type", {24'h0, mpt}, 32'hcf);
        chk("single set", 32'(sets_ok), 32'h4);
        $display("test single packet done");
        apb(1'b1, 8'h08, 32'hfffc);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk("length refused", rd, 32'h2);
        apb(1'b0, 8'h1c, 32'h0);
        chk("sets after refusal", rd, 32'h4);
        chk("sets dropped", 32'(drops), 32'h0);
        chk("bad bytes", 32'(bad), 32'h0);
        chk("destination", out_dest_ip, 32'hef00_3330);
        $display("test length limit done");
        print_verdict();
    end
endmodule : sspf_framer_tb

// ==== sim/sspf_sink.sv ====
`timescale 1ns/1ns
module sspf_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic sop,
    input wire logic eop,
    output logic ready,
    output logic [7:0] mpt,
    output logic [31:0] ts,
    output logic [7:0] tok,
    output int pkts,
    output int sets_ok,
    output int drops,
    output int bad
);
    // ==========================================
    // receiver: joins a set, drops it on loss
    int bi, sb, idx;
    logic [15:0] slen, last_seq;
    logic [7:0] seq_hi, exp_b;
    logic tick, lost;
    assign idx = sop ? 0 : bi;
    assign ready = !slow || tick; // slow mode stalls every other cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
            bi <= 0;
            sb <= 0;
            lost <= 1'b0;
            exp_b <= 8'h00;
            pkts <= 0;
            sets_ok <= 0;
            drops <= 0;
            bad <= 0;
        end else begin
            tick <= !tick;
            if (valid && ready) begin
                bi <= idx + 1;
                if (idx == 1) mpt <= data;
                if (idx == 2) seq_hi <= data;
                if (idx >= 4 && idx < 8) ts <= {ts[23:0], data};
                if (idx >= 8 && idx < 12 && data != 8'h00) bad <= bad + 1;
                if (idx == 3 && mpt[7]) begin
                    if (sb != 0 && sb < slen) drops <= drops + 1;
                    sb <= 0;
                    lost <= 1'b0;
                end
                if (idx == 3 && !mpt[7] && {seq_hi, data} != last_seq + 16'h0001) begin
                    lost <= 1'b1;
                    drops <= drops + 1;
                end
                if (idx == 3) last_seq <= {seq_hi, data};
                if (idx >= 12 && !lost) begin
                    sb <= sb + 1;
                    if (sb == 0) slen[15:8] <= data;
                    if (sb == 1) slen[7:0] <= data;
                    if (sb == 2 && data != 8'h00) bad <= bad + 1;
                    if (sb == 3) tok <= data;
                    if (sb >= 4 && data != exp_b) bad <= bad + 1;
                    if (sb >= 4) exp_b <= exp_b + 8'h01;
                    if (sb >= 2 && sb + 1 == slen) sets_ok <= sets_ok + 1;
                end
                if (eop) pkts <= pkts + 1;
            end
        end
    end
endmodule : sspf_sink
